// File: sss_host.sv
// host model: drives enable, reads the two open-drain status lines
`timescale 1ns/1ps
module sss_host (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic pg_oe_i,
  input wire logic ka_oe_i,
  output logic enable_o,
  output logic power_good_o,
  output logic keepalive_ok_o
);
  initial enable_o = 1'b0;
  // the host updates its port pin on its own clock edge
  always @(posedge clk_i) begin
    enable_o <= run_i;
  end
  // board pull-ups give high whenever the device lets go
  assign power_good_o = pg_oe_i ? 1'b0 : 1'b1;
  assign keepalive_ok_o = ka_oe_i ? 1'b0 : 1'b1;
endmodule

// File: sss_pkg.sv
// constants shared by the supply sequencer and supervisor
package sss_pkg;
  localparam int CLK_MHZ = 20;
  localparam int TMR_W = 18;
  // timer intervals in microseconds, picked inside the allowed windows
  localparam int POR_TIME_US = 10000;
  localparam int FAULT_TIME_US = 5000;
  localparam int MAIN_DLY_US = 5000;
  localparam int KA_DLY_US = 5000;
  localparam int SS_STEP_US = 500;
  localparam int POR_CYC = POR_TIME_US * CLK_MHZ;
  localparam int FAULT_CYC = FAULT_TIME_US * CLK_MHZ;
  localparam int MAIN_DLY_CYC = MAIN_DLY_US * CLK_MHZ;
  localparam int KA_DLY_CYC = KA_DLY_US * CLK_MHZ;
  localparam int SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
  localparam logic [4:0] SS_STEPS = 5'h10;
  // synchroniser bit positions
  localparam int S_EN = 0;
  localparam int S_MPWR = 1;
  localparam int S_KPWR = 2;
  localparam int S_MAIN = 3;
  localparam int S_LOW = 4;
  localparam int S_KREF = 5;
  localparam int S_W = 6;
  localparam logic [S_W-1:0] SYNC_RST = 6'h00;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'h0,
    ST_WAIT = 3'h1,
    ST_SOFT = 3'h3,
    ST_RUN = 3'h2,
    ST_FAULT = 3'h6
  } sss_state_type;
endpackage

// File: sss_supervisor.sv
// supply sequencer: standby, power-up delays, soft-start, fault retry, POR
// How it works
// - enable low forces low-current standby
// - enable returning high restarts power-up sequence
// - standby holds gate off, pulls rails low
// - two independent power-up delay timers
// - regulator enabled only after both delays expire
// - bad rails at soft-start end start fault-off
// - fault-off holds regulator off, then retries
// - POR timer starts when soft-start ends good
// - POR expiry releases power-good output
// - power-good pulled low when either rail low
// - power-good released only with rails and POR
// - keep-alive below reference pulls keep-alive-ok low
// - POR interval between 5 and 15 ms
// - fault-off interval between 1 and 10 ms
// - main power-up delay between 1 and 10 ms
// - soft-start steps target in 16 increments
`timescale 1ns/1ps
module sss_supervisor #(
  parameter logic [17:0] POR_CYCLES = 18'(sss_pkg::POR_CYC),
  parameter logic [17:0] FAULT_CYCLES = 18'(sss_pkg::FAULT_CYC),
  parameter logic [17:0] MAIN_DLY_CYCLES = 18'(sss_pkg::MAIN_DLY_CYC),
  parameter logic [17:0] KA_DLY_CYCLES = 18'(sss_pkg::KA_DLY_CYC),
  parameter logic [17:0] SS_STEP_CYCLES = 18'(sss_pkg::SS_STEP_CYC)
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic ENABLE_I,
  input wire logic MAIN_POWER_IN_OK_I,
  input wire logic KEEPALIVE_POWER_IN_OK_I,
  input wire logic MAIN_RAIL_OUT_OK_I,
  input wire logic LOW_RAIL_OUT_OK_I,
  input wire logic KEEPALIVE_SUPPLY_OUT_OK_I,
  output logic REG_ENABLE_O,
  output logic GATE_OFF_O,
  output logic MAIN_RAIL_OUT_PULLDOWN_O,
  output logic LOW_RAIL_OUT_PULLDOWN_O,
  output logic [4:0] SOFT_STEP_O,
  output logic POWER_GOOD_OUT_O,
  output logic POWER_GOOD_OUT_OE_O,
  output logic KEEPALIVE_OK_OUT_O,
  output logic KEEPALIVE_OK_OUT_OE_O
);
  localparam logic [17:0] ONE = 18'h00001;

  logic [sss_pkg::S_W-1:0] meta_q;
  logic [sss_pkg::S_W-1:0] sync_q;
  sss_pkg::sss_state_type st_q, st_d;
  logic [17:0] main_cnt_q, ka_cnt_q, cnt_q;
  logic [4:0] ss_q;
  logic por_done_q;
  logic reg_en_q, standby_q, pg_oe_q, ka_oe_q;
  logic en_s, mpwr_s, kpwr_s, rails_ok, ka_ref_s;
  logic main_done, ka_done, both_done, hit, ss_end;
  logic [17:0] lim;

  // asynchronous pins pass two flops before any logic reads them
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      meta_q <= sss_pkg::SYNC_RST;
      sync_q <= sss_pkg::SYNC_RST;
    end else begin
      meta_q <= {KEEPALIVE_SUPPLY_OUT_OK_I, LOW_RAIL_OUT_OK_I,
                 MAIN_RAIL_OUT_OK_I, KEEPALIVE_POWER_IN_OK_I,
                 MAIN_POWER_IN_OK_I, ENABLE_I};
      sync_q <= meta_q;
    end
  end

  assign en_s = sync_q[sss_pkg::S_EN];
  assign mpwr_s = sync_q[sss_pkg::S_MPWR];
  assign kpwr_s = sync_q[sss_pkg::S_KPWR];
  assign rails_ok = sync_q[sss_pkg::S_MAIN] & sync_q[sss_pkg::S_LOW];
  assign ka_ref_s = sync_q[sss_pkg::S_KREF];

  // power-up delay timers; a dropout restarts the qualification
  assign main_done = (main_cnt_q == MAIN_DLY_CYCLES);
  assign ka_done = (ka_cnt_q == KA_DLY_CYCLES);
  assign both_done = main_done & ka_done;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || !en_s || !mpwr_s) begin
      main_cnt_q <= '0;
    end else if (!main_done) begin
      main_cnt_q <= main_cnt_q + ONE;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || !en_s || !kpwr_s) begin
      ka_cnt_q <= '0;
    end else if (!ka_done) begin
      ka_cnt_q <= ka_cnt_q + ONE;
    end
  end

  // one phase timer serves soft-start steps, fault-off and POR
  always_comb begin
    unique case (st_q)
      sss_pkg::ST_SOFT: lim = SS_STEP_CYCLES;
      sss_pkg::ST_RUN: lim = POR_CYCLES;
      default: lim = FAULT_CYCLES;
    endcase
  end

  assign hit = (cnt_q == lim - ONE);
  assign ss_end = (st_q == sss_pkg::ST_SOFT) && hit &&
                  (ss_q == sss_pkg::SS_STEPS);

  always_comb begin
    st_d = st_q;
    if (!en_s) begin
      st_d = sss_pkg::ST_STANDBY;
    end else begin
      unique case (st_q)
        sss_pkg::ST_STANDBY: st_d = sss_pkg::ST_WAIT;
        sss_pkg::ST_WAIT: begin
          if (both_done) begin
            st_d = sss_pkg::ST_SOFT;
          end
        end
        sss_pkg::ST_SOFT: begin
          if (!both_done) begin
            st_d = sss_pkg::ST_WAIT;
          end else if (ss_end) begin
            st_d = rails_ok ? sss_pkg::ST_RUN : sss_pkg::ST_FAULT;
          end
        end
        sss_pkg::ST_RUN: begin
          if (!both_done) begin
            st_d = sss_pkg::ST_WAIT;
          end else if (!rails_ok) begin
            st_d = sss_pkg::ST_FAULT;
          end
        end
        sss_pkg::ST_FAULT: begin
          if (hit) begin
            st_d = sss_pkg::ST_WAIT;
          end
        end
        default: st_d = sss_pkg::ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st_q <= sss_pkg::ST_STANDBY;
    end else begin
      st_q <= st_d;
    end
  end

  // timer restarts on every state change, so standby clears it too
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || st_d != st_q) begin
      cnt_q <= '0;
    end else if (hit) begin
      cnt_q <= (st_q == sss_pkg::ST_SOFT) ? '0 : cnt_q;
    end else begin
      cnt_q <= cnt_q + ONE;
    end
  end

  // target starts at zero and climbs one step per interval
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || st_q != sss_pkg::ST_SOFT) begin
      ss_q <= '0;
    end else if (hit && ss_q != sss_pkg::SS_STEPS) begin
      ss_q <= ss_q + 5'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || st_q != sss_pkg::ST_RUN) begin
      por_done_q <= 1'b0;
    end else if (hit) begin
      por_done_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      reg_en_q <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      reg_en_q <= (st_d == sss_pkg::ST_SOFT) ||
                  (st_d == sss_pkg::ST_RUN);
      standby_q <= (st_d == sss_pkg::ST_STANDBY);
    end
  end

  // open-drain pins: enable high means pulling low
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pg_oe_q <= 1'b1;
      ka_oe_q <= 1'b1;
    end else begin
      pg_oe_q <= !(st_q == sss_pkg::ST_RUN && por_done_q &&
                   rails_ok);
      ka_oe_q <= !ka_ref_s;
    end
  end

  assign REG_ENABLE_O = reg_en_q;
  assign GATE_OFF_O = !reg_en_q;
  assign MAIN_RAIL_OUT_PULLDOWN_O = standby_q;
  assign LOW_RAIL_OUT_PULLDOWN_O = standby_q;
  assign SOFT_STEP_O = ss_q;
  assign POWER_GOOD_OUT_O = 1'b0;
  assign POWER_GOOD_OUT_OE_O = pg_oe_q;
  assign KEEPALIVE_OK_OUT_O = 1'b0;
  assign KEEPALIVE_OK_OUT_OE_O = ka_oe_q;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence ss_good_end_s;
    ss_end && both_done && en_s && rails_ok;
  endsequence

  standby_entry_a: assert property (
    !en_s |=> st_q == sss_pkg::ST_STANDBY)
    else $error("standby not entered");
  wake_restart_a: assert property (
    st_q == sss_pkg::ST_STANDBY && en_s |=> st_q == sss_pkg::ST_WAIT)
    else $error("wake-up not taken");
  standby_pins_a: assert property (
    st_q == sss_pkg::ST_STANDBY |-> GATE_OFF_O && !REG_ENABLE_O &&
    MAIN_RAIL_OUT_PULLDOWN_O && LOW_RAIL_OUT_PULLDOWN_O)
    else $error("standby outputs wrong");
  delay_qualify_a: assert property (!mpwr_s |=> !main_done)
    else $error("main delay survived dropout");
  enable_gate_a: assert property (
    $rose(REG_ENABLE_O) |-> $past(both_done))
    else $error("regulator enabled early");
  fault_entry_a: assert property (
    st_q == sss_pkg::ST_RUN && both_done && en_s && !rails_ok
    |=> st_q == sss_pkg::ST_FAULT)
    else $error("rail fault missed");
  fault_hold_a: assert property (
    st_q == sss_pkg::ST_FAULT && !hit && en_s
    |=> st_q == sss_pkg::ST_FAULT ##1 !REG_ENABLE_O)
    else $error("regulator on during fault-off");
  por_start_a: assert property (
    ss_good_end_s |=> st_q == sss_pkg::ST_RUN && cnt_q == 18'h0)
    else $error("por timer not started");
  pg_release_a: assert property (
    !POWER_GOOD_OUT_OE_O |-> $past(por_done_q && rails_ok))
    else $error("power-good released early");
  pg_low_a: assert property (!rails_ok |=> POWER_GOOD_OUT_OE_O)
    else $error("power-good not pulled low");
  pg_window_a: assert property (
    st_q == sss_pkg::ST_RUN && por_done_q && rails_ok && en_s
    |=> !POWER_GOOD_OUT_OE_O)
    else $error("power-good not released");
  ka_low_a: assert property (!ka_ref_s |=> KEEPALIVE_OK_OUT_OE_O)
    else $error("keep-alive-ok not pulled low");
  ss_step_a: assert property (
    st_q == sss_pkg::ST_SOFT && $changed(ss_q) |-> ss_q == $past(ss_q) + 5'h01)
    else $error("soft-start step wrong");
  standby_clear_a: assert property (
    !en_s |=> main_cnt_q == 18'h0 && ka_cnt_q == 18'h0 ##1 POWER_GOOD_OUT_OE_O)
    else $error("standby left timers running");
endmodule

// File: sss_tb.sv
// self-checking testbench for the supply sequencer and supervisor
`timescale 1ns/1ps
module tb;
  localparam int POR = 40;
  localparam int FLT = 20;
  localparam int DLY = 10;
  localparam int SS = 4;
  logic clk, rst, run, mp, kp, mr, lr, ko, en, pg, ka;
  logic reg_en, gate_off, pd_m, pd_l, pg_d, pg_oe, ka_d, ka_oe;
  logic [4:0] step, mx;
  int n_errors, checks_done, n;
  sss_host host (.clk_i(clk), .run_i(run), .pg_oe_i(pg_oe),
    .ka_oe_i(ka_oe), .enable_o(en), .power_good_o(pg),
    .keepalive_ok_o(ka));
  sss_supervisor #(.POR_CYCLES(18'(POR)), .FAULT_CYCLES(18'(FLT)),
    .MAIN_DLY_CYCLES(18'(DLY)), .KA_DLY_CYCLES(18'(DLY)),
    .SS_STEP_CYCLES(18'(SS))) uut (.CLK_I(clk), .SYS_RST_I(rst),
    .ENABLE_I(en), .MAIN_POWER_IN_OK_I(mp), .KEEPALIVE_POWER_IN_OK_I(kp),
    .MAIN_RAIL_OUT_OK_I(mr), .LOW_RAIL_OUT_OK_I(lr),
    .KEEPALIVE_SUPPLY_OUT_OK_I(ko), .REG_ENABLE_O(reg_en),
    .GATE_OFF_O(gate_off), .MAIN_RAIL_OUT_PULLDOWN_O(pd_m),
    .LOW_RAIL_OUT_PULLDOWN_O(pd_l), .SOFT_STEP_O(step),
    .POWER_GOOD_OUT_O(pg_d), .POWER_GOOD_OUT_OE_O(pg_oe),
    .KEEPALIVE_OK_OUT_O(ka_d), .KEEPALIVE_OK_OUT_OE_O(ka_oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs always move 2 ns after the edge; tracks the highest step seen
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      #2;
      if (step > mx) mx = step;
    end
  endtask
  // sel picks the power-good line, else the regulator enable
  task automatic wt(input bit sel, input logic v, input int lim);
    n = 0;
    while ((sel ? pg : reg_en) !== v) begin
      if (n >= lim) begin
        n_errors++;
        $display("Error at %0t: wait ran out", $time);
        conclude();
      end
      tick(1);
      n++;
    end
  endtask
  function automatic logic [4:0] in_rng(input int lo, input int hi);
    return {4'h0, n >= lo && n <= hi};
  endfunction
  task automatic t_powerup();
    run = 1'b1;
    wt(1'b0, 1'b1, DLY + 20);
    chk(in_rng(DLY, DLY + 6), 5'h01);
    chk({2'h0, gate_off, pd_m, pd_l}, 5'h00);
    mx = 5'h00;
    wt(1'b1, 1'b1, SS * 17 + POR + 20);
    chk(in_rng(SS * 17 + POR, SS * 17 + POR + 6), 5'h01);
    chk(mx, 5'h10);
  endtask
  task automatic t_raildrop();
    mr = 1'b0;
    tick(5);
    chk({3'h0, pg, reg_en}, 5'h00);
    mr = 1'b1;
    wt(1'b0, 1'b1, FLT + DLY + 20);
    chk(in_rng(FLT - 5, FLT + DLY + 6), 5'h01);
    wt(1'b1, 1'b1, SS * 17 + POR + 20);
    chk({4'h0, pg}, 5'h01);
  endtask
  task automatic t_standby_lowbad();
    run = 1'b0;
    tick(6);
    chk({reg_en, gate_off, pd_m, pd_l, pg}, 5'h0e);
    lr = 1'b0;
    run = 1'b1;
    wt(1'b0, 1'b1, DLY + 20);
    wt(1'b0, 1'b0, SS * 17 + 10);
    chk(in_rng(SS * 17, SS * 17 + 6), 5'h01);
    chk({4'h0, pg}, 5'h00);
    lr = 1'b1;
  endtask
  task automatic t_kadelay();
    run = 1'b0;
    mp = 1'b0;
    kp = 1'b0;
    tick(6);
    run = 1'b1;
    tick(DLY * 3);
    chk({4'h0, reg_en}, 5'h00);
    mp = 1'b1;
    tick(DLY * 3);
    chk({4'h0, reg_en}, 5'h00);
    kp = 1'b1;
    wt(1'b0, 1'b1, DLY + 20);
    chk(in_rng(DLY, DLY + 6), 5'h01);
  endtask
  task automatic t_keepalive();
    ko = 1'b0;
    tick(5);
    chk({4'h0, ka}, 5'h00);
    ko = 1'b1;
    tick(5);
    chk({4'h0, ka}, 5'h01);
  endtask
  initial begin
    {rst, run, mp, kp, mr, lr, ko} = 7'h5f;
    mx = 5'h00;
    n_errors = 0;
    checks_done = 0;
    tick(3);
    rst = 1'b0;
    tick(4);
    chk({reg_en, gate_off, pd_m, pd_l, pg}, 5'h0e);
    chk({3'h0, pg_d, ka_d}, 5'h00);
    t_powerup();
    t_raildrop();
    t_standby_lowbad();
    t_kadelay();
    t_keepalive();
    conclude();
  end
endmodule
